/* File: rtl/ccpd_pkg.sv */
// Constants and types for the charge comparison pulse discriminator
// Notes on behaviour
// - Accept sample stream, signal only neutrons
// - Main FSM sequences filter, threshold, integrators, correction
// - Eighth-order moving average before threshold
// - Threshold crossing pulses the main controller
// - Recursive integrals; baseline is 32 preceding samples
// - Each integrator raises a done flag
// - Match unit waits for last done, starts correction
// - Subtract scaled mean baseline from slow, fast
// - Neutron when slow at least ratio times fast shifted left by fshift
// - Six PISO registers shift results out serially
// - Trigger request per neutron toward leaf
`default_nettype none
package ccpd_pkg;
  localparam int SAMPLE_RATE_MSPS = 200;
  localparam int CLK_PERIOD_NS = 25;
  localparam int SW = 16;
  localparam int IW = 32;
  localparam int MA_ORDER = 8;
  localparam int MA_SHIFT = 3;
  localparam int BASE_LEN = 32;
  localparam int BASE_SHIFT = 5;
  localparam int PISO_COUNT = 6;
  localparam int PISO_BITS = IW;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_THRESH = 8'h04;
  localparam logic [7:0] OFF_FAST_LEN = 8'h08;
  localparam logic [7:0] OFF_SLOW_LEN = 8'h0c;
  localparam logic [7:0] OFF_ALPHA = 8'h10;
  localparam logic [7:0] OFF_BETA = 8'h14;
  localparam logic [7:0] OFF_RATIO = 8'h18;
  localparam logic [7:0] OFF_FSHIFT = 8'h1c;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_NCOUNT = 8'h24;
  localparam logic [7:0] OFF_GCOUNT = 8'h28;
  localparam logic [7:0] OFF_IS = 8'h2c;
  localparam logic [7:0] OFF_IF = 8'h30;
  localparam logic [7:0] OFF_IB = 8'h34;
  // Reset values
  localparam logic [SW-1:0] RST_THRESH = 16'h0100;
  localparam logic [7:0] RST_FAST_LEN = 8'h0c;
  localparam logic [7:0] RST_SLOW_LEN = 8'h40;
  localparam logic [7:0] RST_ALPHA = 8'h05;
  localparam logic [7:0] RST_BETA = 8'h64;
  localparam logic [15:0] RST_RATIO = 16'h0001;
  localparam logic [4:0] RST_FSHIFT = 5'h00;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
  localparam logic [5:0] PISO_CNT_LAST = 6'h1f;
  typedef enum logic [2:0] {
    CCPD_IDLE = 3'b000,
    CCPD_ARM = 3'b001,
    CCPD_FAST = 3'b010,
    CCPD_SLOW = 3'b011,
    CCPD_MATCH = 3'b100,
    CCPD_CORR = 3'b101,
    CCPD_DECIDE = 3'b110
  } ccpd_state_t;
endpackage
`default_nettype wire

/* File: rtl/ccpd_piso.sv */
// Six parallel-in serial-out registers for logic analyser readout
`default_nettype none
module ccpd_piso
  import ccpd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load,
  input wire logic [PISO_COUNT*PISO_BITS-1:0] par_in,
  output logic [PISO_COUNT-1:0] ser_out,
  output logic ser_valid
);
  typedef struct packed {
    logic [PISO_COUNT-1:0][PISO_BITS-1:0] sh;
    logic [5:0] cnt;
    logic busy;
  } ccpd_piso_st_t;
  ccpd_piso_st_t s_reg, s_next;
  always_comb begin
    s_next = s_reg;
    if (load) begin
      s_next.sh = par_in;
      s_next.cnt = '0;
      s_next.busy = 1'b1;
    end else if (s_reg.busy) begin
      for (int i = 0; i < PISO_COUNT; i++) begin
        s_next.sh[i] = {s_reg.sh[i][PISO_BITS-2:0], 1'b0};
      end
      s_next.cnt = s_reg.cnt + 6'h01;
      if (s_reg.cnt == PISO_CNT_LAST) s_next.busy = 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) s_reg <= '0;
    else s_reg <= s_next;
  end
  // MSB first, one bit per lane per cycle
  genvar g;
  generate
    for (g = 0; g < PISO_COUNT; g++) begin : g_lane
      assign ser_out[g] = s_reg.sh[g][PISO_BITS-1];
    end
  endgenerate
  assign ser_valid = s_reg.busy;
endmodule
`default_nettype wire

/* File: rtl/ccpd_top.sv */
// Charge comparison pulse discriminator with AXI4-Lite control
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
`default_nettype none
module ccpd_top
  import ccpd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [SW-1:0] sample,
  input wire logic sample_valid,
  output logic trig_req,
  output logic [PISO_COUNT-1:0] piso_data,
  output logic piso_valid,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef struct packed {
    // Configuration
    logic enable;
    logic [SW-1:0] thresh;
    logic [7:0] fast_len;
    logic [7:0] slow_len;
    logic [7:0] alpha;
    logic [7:0] beta;
    logic [15:0] ratio;
    logic [4:0] fshift;
    // Bus
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic awrdy;
    logic wrdy;
    logic arrdy;
    // Datapath
    logic [MA_ORDER-1:0][SW-1:0] ma_tap;
    logic [SW+MA_SHIFT-1:0] ma_sum;
    logic above;
    logic [BASE_LEN-1:0][SW-1:0] hist;
    logic [IW-1:0] base_run;
    ccpd_state_t st;
    logic [7:0] cnt;
    logic [IW-1:0] i_b;
    logic [IW-1:0] i_f;
    logic [IW-1:0] i_s;
    logic [2:0] done;
    logic [IW-1:0] c_f;
    logic [IW-1:0] c_s;
    logic last_n;
    logic trig;
    logic piso_load;
    logic [31:0] ncount;
    logic [31:0] gcount;
  } ccpd_st_t;
  ccpd_st_t s_reg, s_next;

  // Decodes a byte offset to a valid-register flag
  function automatic logic ccpd_mapped(input logic [7:0] a);
    ccpd_mapped = (a[1:0] == 2'b00) && (a <= OFF_IB);
  endfunction

  // Byte-lane merge for writable registers
  function automatic logic [31:0] ccpd_merge(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = d[i*8 +: 8];
    end
    ccpd_merge = r;
  endfunction

  logic [SW-1:0] ma_avg;
  logic [IW-1:0] base_mean;
  logic [IW+8-1:0] sub_f;
  logic [IW+8-1:0] sub_s;
  logic [IW+16-1:0] rhs;
  logic signed [IW+16:0] lhs_s;
  logic signed [IW+16:0] rhs_s;
  logic [31:0] wr_val;
  logic [31:0] rd_val;

  assign ma_avg = s_reg.ma_sum[SW+MA_SHIFT-1:MA_SHIFT];
  assign base_mean = s_reg.i_b >> BASE_SHIFT;
  assign sub_f = base_mean * s_reg.alpha;
  assign sub_s = base_mean * s_reg.beta;
  // Fast integral is pre-scaled by 2^fshift so the ratio stays integer
  assign rhs = (s_reg.c_f << s_reg.fshift) * s_reg.ratio;
  assign lhs_s = $signed({{17{s_reg.c_s[IW-1]}}, s_reg.c_s});
  assign rhs_s = $signed({1'b0, rhs});

  always_comb begin
    rd_val = 32'h0;
    unique case (s_axi_araddr)
      OFF_CTRL: rd_val = {31'h0, s_reg.enable};
      OFF_THRESH: rd_val = {16'h0, s_reg.thresh};
      OFF_FAST_LEN: rd_val = {24'h0, s_reg.fast_len};
      OFF_SLOW_LEN: rd_val = {24'h0, s_reg.slow_len};
      OFF_ALPHA: rd_val = {24'h0, s_reg.alpha};
      OFF_BETA: rd_val = {24'h0, s_reg.beta};
      OFF_RATIO: rd_val = {16'h0, s_reg.ratio};
      OFF_FSHIFT: rd_val = {27'h0, s_reg.fshift};
      OFF_STATUS: rd_val = {26'h0, s_reg.last_n, s_reg.above, 1'b0, s_reg.st};
      OFF_NCOUNT: rd_val = s_reg.ncount;
      OFF_GCOUNT: rd_val = s_reg.gcount;
      OFF_IS: rd_val = s_reg.c_s;
      OFF_IF: rd_val = s_reg.c_f;
      OFF_IB: rd_val = s_reg.i_b;
      default: rd_val = 32'h0;
    endcase
  end

  always_comb begin
    s_next = s_reg;
    wr_val = 32'h0;
    // AXI4-Lite write: address and data in either order
    if (s_axi_awvalid && !s_reg.aw_got && !s_reg.bvalid) begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_reg.w_got && !s_reg.bvalid) begin
      s_next.w_got = 1'b1;
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
    end
    if (s_reg.aw_got && s_reg.w_got) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = ccpd_mapped(s_reg.awaddr) ? AXI_OKAY : AXI_SLVERR;
      unique case (s_reg.awaddr)
        OFF_CTRL: begin
          wr_val = ccpd_merge({31'h0, s_reg.enable}, s_reg.wdata, s_reg.wstrb);
          s_next.enable = wr_val[0];
        end
        OFF_THRESH: begin
          wr_val = ccpd_merge({16'h0, s_reg.thresh}, s_reg.wdata, s_reg.wstrb);
          s_next.thresh = wr_val[SW-1:0];
        end
        OFF_FAST_LEN: begin
          wr_val = ccpd_merge({24'h0, s_reg.fast_len}, s_reg.wdata, s_reg.wstrb);
          s_next.fast_len = wr_val[7:0];
        end
        OFF_SLOW_LEN: begin
          wr_val = ccpd_merge({24'h0, s_reg.slow_len}, s_reg.wdata, s_reg.wstrb);
          s_next.slow_len = wr_val[7:0];
        end
        OFF_ALPHA: begin
          wr_val = ccpd_merge({24'h0, s_reg.alpha}, s_reg.wdata, s_reg.wstrb);
          s_next.alpha = wr_val[7:0];
        end
        OFF_BETA: begin
          wr_val = ccpd_merge({24'h0, s_reg.beta}, s_reg.wdata, s_reg.wstrb);
          s_next.beta = wr_val[7:0];
        end
        OFF_RATIO: begin
          wr_val = ccpd_merge({16'h0, s_reg.ratio}, s_reg.wdata, s_reg.wstrb);
          s_next.ratio = wr_val[15:0];
        end
        OFF_FSHIFT: begin
          wr_val = ccpd_merge({27'h0, s_reg.fshift}, s_reg.wdata, s_reg.wstrb);
          s_next.fshift = wr_val[4:0];
        end
        default: wr_val = 32'h0;
      endcase
    end
    if (s_reg.bvalid && s_axi_bready) s_next.bvalid = 1'b0;
    if (s_axi_arvalid && !s_reg.rvalid) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = rd_val;
      s_next.rresp = ccpd_mapped(s_axi_araddr) ? AXI_OKAY : AXI_SLVERR;
    end else if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    // Ready leaves a flip-flop, so it is worked out from next state one cycle ahead
    s_next.awrdy = !s_next.aw_got && !s_next.bvalid;
    s_next.wrdy = !s_next.w_got && !s_next.bvalid;
    s_next.arrdy = !s_next.rvalid;

    s_next.trig = 1'b0;
    s_next.piso_load = 1'b0;
    if (sample_valid) begin
      // Moving average and baseline history run continuously
      s_next.ma_tap = {s_reg.ma_tap[MA_ORDER-2:0], sample};
      s_next.ma_sum = s_reg.ma_sum + (SW+MA_SHIFT)'(sample)
                      - (SW+MA_SHIFT)'(s_reg.ma_tap[MA_ORDER-1]);
      s_next.above = ma_avg >= s_reg.thresh;
      s_next.hist = {s_reg.hist[BASE_LEN-2:0], sample};
      s_next.base_run = s_reg.base_run + IW'(sample)
                        - IW'(s_reg.hist[BASE_LEN-1]);
    end
    unique case (s_reg.st)
      CCPD_IDLE: if (s_reg.enable) s_next.st = CCPD_ARM;
      CCPD_ARM: begin
        if (!s_reg.enable) s_next.st = CCPD_IDLE;
        else if (sample_valid && ma_avg >= s_reg.thresh && !s_reg.above) begin
          // Baseline is the 32 samples before the crossing, frozen here
          s_next.i_b = s_reg.base_run;
          s_next.done = 3'b001;
          s_next.i_f = IW'(sample);
          s_next.i_s = '0;
          s_next.cnt = 8'h01;
          s_next.st = CCPD_FAST;
        end
      end
      CCPD_FAST: if (sample_valid) begin
        if (s_reg.cnt >= s_reg.fast_len) begin
          s_next.done[1] = 1'b1;
          s_next.i_s = IW'(sample);
          s_next.cnt = 8'h01;
          s_next.st = CCPD_SLOW;
        end else begin
          s_next.i_f = s_reg.i_f + IW'(sample);
          s_next.cnt = s_reg.cnt + 8'h01;
        end
      end
      CCPD_SLOW: if (sample_valid) begin
        if (s_reg.cnt >= s_reg.slow_len) begin
          s_next.done[2] = 1'b1;
          s_next.st = CCPD_MATCH;
        end else begin
          s_next.i_s = s_reg.i_s + IW'(sample);
          s_next.cnt = s_reg.cnt + 8'h01;
        end
      end
      CCPD_MATCH: if (&s_reg.done) s_next.st = CCPD_CORR;
      CCPD_CORR: begin
        s_next.c_f = s_reg.i_f - sub_f[IW-1:0];
        s_next.c_s = s_reg.i_s - sub_s[IW-1:0];
        s_next.st = CCPD_DECIDE;
      end
      CCPD_DECIDE: begin
        // Signed compare: a negative corrected slow integral is never a neutron
        s_next.last_n = lhs_s >= rhs_s;
        s_next.trig = lhs_s >= rhs_s;
        if (lhs_s >= rhs_s) s_next.ncount = s_reg.ncount + 32'h1;
        else s_next.gcount = s_reg.gcount + 32'h1;
        s_next.piso_load = 1'b1;
        s_next.done = 3'b000;
        s_next.st = CCPD_ARM;
      end
      default: s_next.st = CCPD_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.thresh <= RST_THRESH;
      s_reg.fast_len <= RST_FAST_LEN;
      s_reg.slow_len <= RST_SLOW_LEN;
      s_reg.alpha <= RST_ALPHA;
      s_reg.beta <= RST_BETA;
      s_reg.ratio <= RST_RATIO;
      s_reg.fshift <= RST_FSHIFT;
      s_reg.st <= CCPD_IDLE;
      s_reg.awrdy <= 1'b1;
      s_reg.wrdy <= 1'b1;
      s_reg.arrdy <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  ccpd_piso u_piso (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(s_reg.piso_load),
    .par_in({s_reg.i_s, s_reg.i_f, s_reg.i_b, s_reg.c_s, s_reg.c_f, 31'h0, s_reg.last_n}),
    .ser_out(piso_data),
    .ser_valid(piso_valid)
  );

  assign trig_req = s_reg.trig;
  assign s_axi_awready = s_reg.awrdy;
  assign s_axi_wready = s_reg.wrdy;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.arrdy;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
endmodule
`default_nettype wire

/* File: testbench/ccpd_props.sv */
// Port checker for the pulse discriminator
`default_nettype none
module ccpd_props
  import ccpd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic trig_req,
  input wire logic piso_valid,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] pcnt;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Counts consecutive shift cycles so the 32-cycle window can be checked
  always_ff @(posedge aclk) pcnt <= (!aresetn || !piso_valid) ? 6'h00 : pcnt + 6'h01;
  AST_TRIG_ONE: assert property (trig_req |=> !trig_req)
    else $error("trigger request longer than one cycle");
  AST_TRIG_PISO: assert property (trig_req |-> ##[0:2] piso_valid)
    else $error("no serial readout around trigger");
  AST_PISO_LEN: assert property ($fell(piso_valid) |-> pcnt == 6'h20)
    else $error("serial readout not 32 cycles");
  AST_PISO_MAX: assert property (piso_valid |-> pcnt < 6'h20)
    else $error("serial readout too long");
  AST_RESET_QUIET: assert property ($rose(aresetn) |-> !trig_req && !piso_valid
    && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
  AST_B_AFTER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  AST_R_AFTER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  cover property (trig_req);
  cover property ($fell(piso_valid));
  cover property (s_axi_bvalid && s_axi_bresp == AXI_SLVERR);
endmodule
bind ccpd_top ccpd_props u_props(.aclk, .aresetn, .trig_req, .piso_valid, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid);
`default_nettype wire

/* File: testbench/ccpd_leaf_model.sv */
// Trigger leaf and logic analyser stand-in
`default_nettype none
module ccpd_leaf_model
  import ccpd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic trig_req,
  input wire logic [PISO_COUNT-1:0] piso_data,
  input wire logic piso_valid,
  output logic [15:0] n_trig,
  output logic [PISO_COUNT-1:0][31:0] cap
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      n_trig <= '0;
    end else if (trig_req) begin
      n_trig <= n_trig + 16'h0001;
    end
    // Lanes arrive MSB first, so a plain left shift rebuilds each word
    if (piso_valid) begin
      for (int i = 0; i < PISO_COUNT; i++) cap[i] <= {cap[i][30:0], piso_data[i]};
    end
  end
endmodule
`default_nettype wire

/* File: testbench/test_charge_comparison_pulse_discriminator.sv */
// Self-checking bench for the pulse discriminator
`default_nettype none
module test_charge_comparison_pulse_discriminator
  import ccpd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = '0, aresetn = '0, sample_valid = '0, trig_req, piso_valid;
  logic [SW-1:0] sample = '0;
  logic [5:0] piso_data;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [15:0] n_trig;
  logic [5:0][31:0] cap;
  int n_errors = 0, tests_run = 0, cyc = 0, n_neu = 0, n_gam = 0, rt = 1, sh = 0, al = 5;
  int b, f, s, mb;
  logic en = '0;
  logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
  logic [31:0] rv [8] = '{32'h0, 32'h100, 32'hc, 32'h40, 32'h5, 32'h64, 32'h1, 32'h0};
  ccpd_top u_dut(.aclk, .aresetn, .sample, .sample_valid, .trig_req, .piso_data, .piso_valid,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  ccpd_leaf_model u_leaf(.aclk, .aresetn, .trig_req, .piso_data, .piso_valid, .n_trig, .cap);
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      finish_test();
    end
  end
  // Neutron when the corrected slow integral reaches ratio times the scaled corrected fast one
  function automatic logic decide(int cs, int cf);
    return cs >= (cf << sh) * rt;
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Ready is sampled on the falling edge, where it is settled, and acted on at the next rise
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] st);
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = '0;
    while (!tb) begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= '0;
      if (tw) s_axi_wvalid <= '0;
    end
    s_axi_bready <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic ta, tb;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tb = '0;
    while (!tb) begin
      @(negedge aclk);
      ta = s_axi_arready;
      tb = s_axi_rvalid;
      v = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= '0;
    end
    s_axi_rready <= '0;
  endtask
  // Random idle cycles carry junk that must not enter the filter
  task automatic smp(input int v);
    @(posedge aclk);
    if ($urandom % 8 == 0) begin
      sample_valid <= '0;
      sample <= SW'($urandom);
      @(posedge aclk);
    end
    sample_valid <= 1'b1;
    sample <= SW'(v);
  endtask
  // The filter average lags one sample, so the crossing lands on the second high sample:
  // the baseline then holds one high sample, and fast and slow each take one later sample
  task automatic pulse(input int b, input int f, input int s);
    logic [31:0] e [6];
    logic dec;
    int t0, ib, m, fi, si;
    t0 = n_trig;
    ib = 31 * b + f;
    m = ib / 32;
    fi = 11 * f + s;
    si = 63 * s + b;
    dec = decide(si - 100 * m, fi - al * m);
    e = '{32'(dec), 32'(fi - al * m), 32'(si - 100 * m), 32'(ib), 32'(fi), 32'(si)};
    repeat (40) smp(b);
    repeat (12) smp(f);
    repeat (64) smp(s);
    repeat (45) smp(b);
    chk("trigger count", 32'(t0 + int'(en && dec)), 32'(n_trig));
    if (en) begin
      for (int i = 0; i < 6; i++) chk("piso lane", e[i], cap[i]);
      rd(8'h2c, d);
      chk("corrected slow", e[2], d);
      rd(8'h30, d);
      chk("corrected fast", e[1], d);
      rd(8'h34, d);
      chk("baseline sum", e[3], d);
      if (dec) n_neu++;
      else n_gam++;
    end
  endtask
  initial begin
    void'($urandom(32'hdaa79a7c));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ra[i]) begin
      rd(ra[i], d);
      chk("reset value", rv[i], d);
    end
    $display("test reset values done");
    rd(8'h38, d);
    chk("unmapped read", {30'h0, AXI_SLVERR}, {d[29:0], r});
    wr(8'h05, 32'h0, 4'hf);
    chk("misaligned write", {30'h0, AXI_SLVERR}, {30'h0, r});
    wr(8'h04, 32'hffffff80, 4'h1);
    rd(8'h04, d);
    chk("strobed threshold", 32'h180, d);
    wr(8'h04, 32'h100, 4'hf);
    $display("test register bus done");
    pulse(20, 3000, 500);
    $display("test disabled done");
    en = 1'b1;
    wr(8'h00, 32'h1, 4'hf);
    // Equal products must count as neutron, a slow level one lower as gamma
    pulse(0, 3968, 894);
    pulse(0, 3968, 893);
    $display("test boundary done");
    repeat (14) begin
      rt = 1 + $urandom % 3;
      sh = $urandom % 3;
      al = 5 + $urandom % 2;
      wr(8'h18, 32'(rt), 4'hf);
      wr(8'h1c, 32'(sh), 4'hf);
      wr(8'h10, 32'(al), 4'hf);
      b = $urandom % 200;
      f = 2100 + $urandom % 2000;
      // Slow level that balances the decision, then spread to both sides of it
      mb = (31 * b + f) / 32;
      s = ((((11 * f - al * mb) << sh) * rt) + 100 * mb - b) / (63 - (rt << sh));
      s = s + int'($urandom % 61) - 30;
      pulse(b, f, s);
    end
    rd(8'h24, d);
    chk("neutron count", 32'(n_neu), d);
    rd(8'h28, d);
    chk("gamma count", 32'(n_gam), d);
    $display("test random pulses done");
    finish_test();
  end
endmodule
`default_nettype wire
